// [card_host_defs.svh]
`ifndef CARD_HOST_DEFS_SVH
`define CARD_HOST_DEFS_SVH

// clock period and time conversion; times are kept in tenths of a nanosecond
`define CLK_PERIOD_NS10 50
`define NS_TO_CYC(t10) (((t10) + `CLK_PERIOD_NS10 - 1) / `CLK_PERIOD_NS10)

// register byte offsets on the bus
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_STATUS 8'h08
`define OFF_TXDATA 8'h0c
`define OFF_RXDATA 8'h10
`define OFF_ADDR 8'h14
`define OFF_MEMDATA 8'h18
`define OFF_CRC 8'h1c

`define CTRL_RESET 7'h00
`define UDMA_MAX_MODE 3'h4
`define CRC_SEED 16'h4aba
`define CRC_POLY 16'h1021

// typical sustained two-cycle time per mode
`define T_2CYCTYP0_NS10 2400
`define T_2CYCTYP1_NS10 1600
`define T_2CYCTYP2_NS10 1200
`define T_2CYCTYP3_NS10 900
`define T_2CYCTYP4_NS10 600
// ready_to_pause_time per mode
`define T_RP0_NS10 1600
`define T_RP1_NS10 1250
`define T_RP2_NS10 1000
`define T_RP3_NS10 1000
`define T_RP4_NS10 1000
// crc_valid_setup_time per mode
`define T_CVS0_NS10 700
`define T_CVS1_NS10 480
`define T_CVS2_NS10 310
`define T_CVS3_NS10 200
`define T_CVS4_NS10 67
// mode-independent burst times
`define T_DVH_NS10 62
`define T_ACK_NS10 200
`define T_ENV_MIN_NS10 200
`define T_MLI_NS10 200
`define T_SS_NS10 500
// attribute / common memory cycle
`define T_MEM_SETUP_NS10 300
`define T_MEM_PULSE_NS10 3000
`define T_MEM_RECOV_NS10 300

`endif

// [card_host_pkg.sv]
package card_host_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ACK_SETUP = 4'h1,
        ST_ENVELOPE = 4'h3,
        ST_IN_RUN = 4'h2,
        ST_OUT_RUN = 4'h6,
        ST_RP_WAIT = 4'h7,
        ST_TERM = 4'h5,
        ST_MLI_WAIT = 4'h4,
        ST_CRC_SETUP = 4'hc,
        ST_ACK_HOLD = 4'hd,
        ST_MEM_SETUP = 4'hf,
        ST_MEM_STROBE = 4'he,
        ST_MEM_HOLD = 4'ha
    } state_t;

    typedef struct packed {
        logic memWrite;
        logic attrSpace;
        logic dirOut;
        logic [2:0] udmaMode;
        logic ideSel;
    } ctrl_t;

    typedef struct packed {
        logic memAccess;
        logic stopBurst;
        logic startBurst;
    } cmd_t;

    typedef struct packed {
        logic dmarq;
        logic devStrobeRdy;
        logic [15:0] dataIn;
    } card_in_t;

    typedef struct packed {
        logic ideEmulationSelectN;
        logic regN;
        logic ceN;
        logic oeN;
        logic weN;
        logic [10:0] addr;
        logic dmackN;
        logic stop;
        logic hstrobeRdy;
        logic [15:0] dataOut;
        logic dataOe;
    } card_out_t;

    typedef struct packed {
        state_t state;
        logic [7:0] cnt;
        logic [7:0] edgeCnt;
        ctrl_t ctrl;
        logic [10:0] addr;
        logic [15:0] memData;
        logic [15:0] txData;
        logic txValid;
        logic loaded;
        logic [15:0] rxData;
        logic rxValid;
        logic overrun;
        logic armed;
        logic stopReq;
        logic [15:0] crc;
        logic dmarqS1;
        logic dmarqS2;
        logic strbS1;
        logic strbS2;
        logic strbS3;
        logic [15:0] dataS1;
        logic [15:0] dataS2;
        card_out_t pins;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } regs_t;

endpackage

// [card_host_port.sv]
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "card_host_defs.svh"

module card_host_port (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire card_host_pkg::card_in_t cardIn,
    output card_host_pkg::card_out_t cardOut
);
    import card_host_pkg::*;

    regs_t s;
    regs_t n;
    logic done;
    logic strobeEdge;
    logic access;
    logic commit;
    logic isIdle;
    logic burstActive;
    logic [2:0] mode;
    cmd_t cmd;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ `CRC_POLY;
            end
        end
        return r;
    endfunction

    // half of the typical two-cycle time satisfies both edge-to-edge minima
    function automatic logic [7:0] half_cyc(input logic [2:0] m);
        case (m)
            3'h0: return 8'(`NS_TO_CYC(`T_2CYCTYP0_NS10 / 2));
            3'h1: return 8'(`NS_TO_CYC(`T_2CYCTYP1_NS10 / 2));
            3'h2: return 8'(`NS_TO_CYC(`T_2CYCTYP2_NS10 / 2));
            3'h3: return 8'(`NS_TO_CYC(`T_2CYCTYP3_NS10 / 2));
            default: return 8'(`NS_TO_CYC(`T_2CYCTYP4_NS10 / 2));
        endcase
    endfunction

    function automatic logic [7:0] rp_cyc(input logic [2:0] m);
        case (m)
            3'h0: return 8'(`NS_TO_CYC(`T_RP0_NS10));
            3'h1: return 8'(`NS_TO_CYC(`T_RP1_NS10));
            3'h2: return 8'(`NS_TO_CYC(`T_RP2_NS10));
            3'h3: return 8'(`NS_TO_CYC(`T_RP3_NS10));
            default: return 8'(`NS_TO_CYC(`T_RP4_NS10));
        endcase
    endfunction

    function automatic logic [7:0] cvs_cyc(input logic [2:0] m);
        case (m)
            3'h0: return 8'(`NS_TO_CYC(`T_CVS0_NS10));
            3'h1: return 8'(`NS_TO_CYC(`T_CVS1_NS10));
            3'h2: return 8'(`NS_TO_CYC(`T_CVS2_NS10));
            3'h3: return 8'(`NS_TO_CYC(`T_CVS3_NS10));
            default: return 8'(`NS_TO_CYC(`T_CVS4_NS10));
        endcase
    endfunction

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign cardOut = s.pins;

    always_comb begin
        n = s;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.dmarqS1 = cardIn.dmarq;
        n.dmarqS2 = s.dmarqS1;
        n.strbS1 = cardIn.devStrobeRdy;
        n.strbS2 = s.strbS1;
        n.strbS3 = s.strbS2;
        n.dataS1 = cardIn.dataIn;
        n.dataS2 = s.dataS1;
        strobeEdge = s.strbS2 ^ s.strbS3;
        done = (s.cnt == 8'h00);
        if (!done) begin
            n.cnt = s.cnt - 8'h01;
        end
        if (s.edgeCnt != 8'hff) begin
            n.edgeCnt = s.edgeCnt + 8'h01;
        end
        mode = (s.ctrl.udmaMode > `UDMA_MAX_MODE) ? `UDMA_MAX_MODE : s.ctrl.udmaMode;
        isIdle = (s.state == ST_IDLE);
        burstActive = !isIdle && (s.state != ST_MEM_SETUP) && (s.state != ST_MEM_STROBE)
            && (s.state != ST_MEM_HOLD);

        // bus slave: one wait state, writes and read side effects land on the completing edge
        access = psel && penable && !s.pready;
        commit = psel && penable && s.pready;
        cmd = cmd_t'(3'h0);
        if (access) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            case (paddr)
                `OFF_CTRL: n.prdata = 32'(s.ctrl);
                `OFF_CMD: n.prdata = 32'h0000_0000;
                `OFF_STATUS: n.prdata = 32'({s.overrun, s.txValid, s.rxValid, s.dmarqS2, s.armed,
                    !isIdle, s.state});
                `OFF_TXDATA: n.prdata = 32'(s.txData);
                `OFF_RXDATA: n.prdata = 32'(s.rxData);
                `OFF_ADDR: n.prdata = 32'(s.addr);
                `OFF_MEMDATA: n.prdata = 32'(s.memData);
                `OFF_CRC: n.prdata = 32'(s.crc);
                default: n.pslverr = 1'b1;
            endcase
        end
        if (commit && !s.pslverr) begin
            if (pwrite) begin
                case (paddr)
                    `OFF_CTRL: if (isIdle) n.ctrl = ctrl_t'(pwdata[6:0]);
                    `OFF_CMD: cmd = cmd_t'(pwdata[2:0]);
                    `OFF_TXDATA: if (!s.txValid) begin
                        n.txData = pwdata[15:0];
                        n.txValid = 1'b1;
                    end
                    `OFF_ADDR: if (isIdle) n.addr = pwdata[10:0];
                    `OFF_MEMDATA: if (isIdle) n.memData = pwdata[15:0];
                    default: ;
                endcase
            end else if (paddr == `OFF_RXDATA) begin
                n.rxValid = 1'b0;
            end else if (paddr == `OFF_STATUS) begin
                n.overrun = 1'b0;
            end
        end
        if (cmd.stopBurst) begin
            n.armed = 1'b0;
            n.stopReq = burstActive;
        end
        if (cmd.startBurst && isIdle) begin
            n.armed = 1'b1;
        end
        // the strap follows the ideSel control bit from reset onward; the card looks at it only at power-up
        n.pins.ideEmulationSelectN = !s.ctrl.ideSel;

        // data-in capture; a new word beats a clear; the strobe return after stop carries no word
        if (!s.ctrl.dirOut && (s.state == ST_IN_RUN || s.state == ST_RP_WAIT)
            && strobeEdge) begin
            if (n.rxValid) begin
                n.overrun = 1'b1;
            end
            n.rxData = s.dataS2;
            n.rxValid = 1'b1;
            n.crc = crc_step(s.crc, s.dataS2);
        end

        case (s.state)
            ST_IDLE: begin
                if (s.armed && s.dmarqS2) begin
                    n.armed = 1'b0;
                    n.pins.addr = s.addr;
                    n.pins.hstrobeRdy = 1'b1;
                    n.cnt = 8'(`NS_TO_CYC(`T_ACK_NS10));
                    n.state = ST_ACK_SETUP;
                end else if (cmd.memAccess) begin
                    n.pins.addr = s.addr;
                    n.pins.regN = !s.ctrl.attrSpace;
                    n.pins.ceN = 1'b0;
                    n.pins.dataOut = s.memData;
                    n.pins.dataOe = s.ctrl.memWrite;
                    n.cnt = 8'(`NS_TO_CYC(`T_MEM_SETUP_NS10));
                    n.state = ST_MEM_SETUP;
                end
            end
            ST_ACK_SETUP: begin
                if (done) begin
                    n.pins.dmackN = 1'b0;
                    n.cnt = 8'(`NS_TO_CYC(`T_ENV_MIN_NS10));
                    n.state = ST_ENVELOPE;
                end
            end
            ST_ENVELOPE: begin
                if (done) begin
                    n.pins.stop = 1'b0;
                    n.crc = `CRC_SEED;
                    n.stopReq = 1'b0;
                    n.loaded = 1'b0;
                    n.edgeCnt = 8'hff;
                    if (s.ctrl.dirOut) begin
                        n.state = ST_OUT_RUN;
                    end else begin
                        n.pins.hstrobeRdy = 1'b0;
                        n.state = ST_IN_RUN;
                    end
                end
            end
            ST_IN_RUN: begin
                if (!s.dmarqS2) begin
                    n.pins.stop = 1'b1;
                    n.pins.hstrobeRdy = 1'b1;
                    n.state = ST_TERM;
                end else if (s.stopReq) begin
                    n.pins.hstrobeRdy = 1'b1;
                    n.cnt = rp_cyc(mode);
                    n.state = ST_RP_WAIT;
                end else begin
                    // pause while the received word is still unread
                    n.pins.hstrobeRdy = n.rxValid;
                end
            end
            ST_RP_WAIT: begin
                if (done) begin
                    n.pins.stop = 1'b1;
                    n.state = ST_TERM;
                end
            end
            ST_OUT_RUN: begin
                if (s.loaded) begin
                    // device ready low is checked before every edge
                    if (done && !s.strbS2) begin
                        n.pins.hstrobeRdy = !s.pins.hstrobeRdy;
                        n.txValid = 1'b0;
                        n.loaded = 1'b0;
                        n.crc = crc_step(s.crc, s.txData);
                        n.edgeCnt = 8'h00;
                        n.cnt = 8'(`NS_TO_CYC(`T_DVH_NS10));
                    end
                end else if (!s.dmarqS2 || s.stopReq) begin
                    if (s.edgeCnt >= 8'(`NS_TO_CYC(`T_SS_NS10))) begin
                        n.pins.stop = 1'b1;
                        n.state = ST_TERM;
                    end
                end else if (s.txValid && done) begin
                    n.pins.dataOut = s.txData;
                    n.pins.dataOe = 1'b1;
                    n.loaded = 1'b1;
                    n.cnt = half_cyc(mode);
                end
            end
            ST_TERM: begin
                // data-out: strobe returns high; data-in: ready stays negated
                n.pins.hstrobeRdy = 1'b1;
                if (!s.dmarqS2) begin
                    n.cnt = 8'(`NS_TO_CYC(`T_MLI_NS10));
                    n.state = ST_MLI_WAIT;
                end
            end
            ST_MLI_WAIT: begin
                if (done) begin
                    n.pins.dataOut = s.crc;
                    n.pins.dataOe = 1'b1;
                    n.cnt = cvs_cyc(mode);
                    n.state = ST_CRC_SETUP;
                end
            end
            ST_CRC_SETUP: begin
                if (done) begin
                    n.pins.dmackN = 1'b1;
                    n.cnt = 8'(`NS_TO_CYC(`T_ACK_NS10));
                    n.state = ST_ACK_HOLD;
                end
            end
            ST_ACK_HOLD: begin
                if (done) begin
                    n.pins.dataOe = 1'b0;
                    n.stopReq = 1'b0;
                    n.state = ST_IDLE;
                end
            end
            ST_MEM_SETUP: begin
                if (done) begin
                    n.pins.oeN = s.ctrl.memWrite;
                    n.pins.weN = !s.ctrl.memWrite;
                    n.cnt = 8'(`NS_TO_CYC(`T_MEM_PULSE_NS10));
                    n.state = ST_MEM_STROBE;
                end
            end
            ST_MEM_STROBE: begin
                if (done) begin
                    if (!s.ctrl.memWrite) begin
                        n.memData = s.dataS2;
                    end
                    n.pins.oeN = 1'b1;
                    n.pins.weN = 1'b1;
                    n.cnt = 8'(`NS_TO_CYC(`T_MEM_RECOV_NS10));
                    n.state = ST_MEM_HOLD;
                end
            end
            ST_MEM_HOLD: begin
                if (done) begin
                    n.pins.ceN = 1'b1;
                    n.pins.regN = 1'b1;
                    n.pins.dataOe = 1'b0;
                    n.state = ST_IDLE;
                end
            end
            default: n.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            s.state <= ST_IDLE;
            s.ctrl <= ctrl_t'(`CTRL_RESET);
            s.crc <= `CRC_SEED;
            s.pins.ideEmulationSelectN <= 1'b1;
            s.pins.regN <= 1'b1;
            s.pins.ceN <= 1'b1;
            s.pins.oeN <= 1'b1;
            s.pins.weN <= 1'b1;
            s.pins.dmackN <= 1'b1;
            s.pins.stop <= 1'b1;
            s.pins.hstrobeRdy <= 1'b1;
        end else begin
            s <= n;
        end
    end

endmodule

// [card_host_port_assertions.sv]
`timescale 1ns/10ps
module card_host_port_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire card_host_pkg::card_in_t cardIn,
    input wire card_host_pkg::card_out_t cardOut
);
    import card_host_pkg::*;
    logic attrSh, dirSh;
    logic [7:0] sinceEdge, rdyHigh;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // direction and space are only written while idle, so a shadow of the last write is enough
    always_ff @(posedge clock) begin
        if (reset) begin
            attrSh <= 1'b0;
            dirSh <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
            attrSh <= pwdata[5];
            dirSh <= pwdata[4];
        end
    end
    always_ff @(posedge clock) begin
        if (reset || $changed(cardOut.hstrobeRdy)) sinceEdge <= 8'h00;
        else if (sinceEdge != 8'hff) sinceEdge <= sinceEdge + 8'h01;
        if (reset || !cardIn.devStrobeRdy) rdyHigh <= 8'h00;
        else if (rdyHigh != 8'hff) rdyHigh <= rdyHigh + 8'h01;
    end
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    attr_select_a: assert property ($fell(cardOut.ceN) |-> cardOut.regN == !attrSh)
        else $error("attribute select wrong for space");
    select_hold_a: assert property (!cardOut.oeN || !cardOut.weN |->
        !cardOut.ceN && $stable(cardOut.regN) && $stable(cardOut.addr)) else $error("select moved in strobe");
    envelope_a: assert property ($fell(cardOut.dmackN) |-> cardOut.stop [*4] ##[1:10]
        (!cardOut.stop && (dirSh || !cardOut.hstrobeRdy))) else $error("envelope out of range");
    ack_setup_a: assert property ($fell(cardOut.dmackN) |-> cardOut.addr == $past(cardOut.addr, 4))
        else $error("address moved before ack");
    ack_hold_a: assert property ($rose(cardOut.dmackN) |=> $stable(cardOut.addr) [*4])
        else $error("address moved after ack");
    crc_setup_a: assert property ($rose(cardOut.dmackN) |-> cardOut.dataOe && $past(cardOut.dataOe, 2) &&
        cardOut.dataOut == $past(cardOut.dataOut, 2) ##1 cardOut.dataOe) else $error("crc setup short");
    rp_wait_a: assert property ($rose(cardOut.stop) && !cardOut.dmackN && !dirSh && cardIn.dmarq |->
        cardOut.hstrobeRdy && $past(cardOut.hstrobeRdy, 20)) else $error("stop before pause time");
    final_strobe_a: assert property (rdyHigh > 8'd12 && dirSh && !cardOut.dmackN && !cardOut.stop &&
        !$past(cardOut.stop) |-> $stable(cardOut.hstrobeRdy)) else $error("strobe after ready negated");
    strobe_spacing_a: assert property (dirSh && !cardOut.dmackN && !cardOut.stop &&
        $changed(cardOut.hstrobeRdy) |=> $stable(cardOut.hstrobeRdy) [*5]) else $error("strobe edges too close");
    stop_spacing_a: assert property (dirSh && !cardOut.dmackN && $rose(cardOut.stop) |-> sinceEdge >= 8'd9)
        else $error("stop too soon after strobe");
    cover property ($fell(cardOut.dmackN) && dirSh);
    cover property ($fell(cardOut.dmackN) && !dirSh);
    cover property ($fell(cardOut.weN));
endmodule

bind card_host_port card_host_port_checker checker_i (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cardIn(cardIn), .cardOut(cardOut));

// [card_model.sv]
`timescale 1ns/10ps
module card_model #(
    parameter int WORDS = 3,
    parameter bit PIO_ONLY = 1'b0
) (
    input wire logic linkClock,
    input wire logic request,
    input wire logic dirOut,
    input wire card_host_pkg::card_out_t cardOut,
    output card_host_pkg::card_in_t cardIn,
    output logic [31:0] outPair,
    output logic [3:0] outCount,
    output logic [15:0] crcSeen
);
    import card_host_pkg::*;
    logic [15:0] common [8];
    logic ideMode, running, done, phase;
    logic [3:0] sent, stall;
    logic [5:0] cfgIndex;
    logic [31:0] ioBase;
    function automatic logic [15:0] cis(input logic [10:0] a);
        return (a == 11'h200) ? 16'(cfgIndex) :
            (a == 11'h000) ? 16'h0001 : (a == 11'h002) ? 16'h0004 : 16'h00ff;
    endfunction
    // zero means the memory interface
    assign ioBase = (cfgIndex == 6'h2) ? 32'h01f0_03f6 :
        (cfgIndex == 6'h3) ? 32'h0170_0376 : 32'h0000_0000;
    initial begin
        cardIn = '0;
        cardIn.devStrobeRdy = 1'b1;
        {running, done, phase, sent, stall, outCount, outPair, cfgIndex} = '0;
        #10 ideMode = (cardOut.ideEmulationSelectN === 1'b0);
    end
    always @(posedge linkClock) begin
        if (!cardOut.ceN && !cardOut.weN && cardOut.regN) common[cardOut.addr[2:0]] <= cardOut.dataOut;
        if (!cardOut.ceN && !cardOut.weN && !cardOut.regN && !ideMode && cardOut.addr == 11'h200)
            cfgIndex <= cardOut.dataOut[5:0];
        // released data lines keep changing, so a stale value never passes for a read
        if (!cardOut.ceN && !cardOut.oeN && !ideMode)
            cardIn.dataIn <= cardOut.regN ? common[cardOut.addr[2:0]] : cis(cardOut.addr);
        else if (!(running && !dirOut)) cardIn.dataIn <= ~cardIn.dataIn;
        if (!request) begin
            {done, running, phase, sent, stall} <= '0;
            cardIn.dmarq <= 1'b0;
        end else if (!running && !done) begin
            cardIn.dmarq <= !PIO_ONLY;
            running <= !cardOut.dmackN && !cardOut.stop;
            if (!cardOut.dmackN && !cardOut.stop) {phase, cardIn.dataIn} <= {1'b1, 16'h1000};
        end else if (running && cardOut.stop) begin
            {running, done} <= 2'b01;
            cardIn.dmarq <= 1'b0;
            cardIn.devStrobeRdy <= 1'b1;
        end else if (dirOut) begin
            if (outCount == 4'h1 && stall != 4'h4) stall <= stall + 4'h1;
            cardIn.devStrobeRdy <= (outCount == 4'h1 && stall != 4'h4);
        end else if (!cardOut.hstrobeRdy && sent < WORDS) begin
            // word and edge advance only while the host is ready, so a pause never strobes stale data
            phase <= ~phase;
            if (!phase) cardIn.dataIn <= 16'h1000 + 16'(sent);
            else begin
                cardIn.devStrobeRdy <= ~cardIn.devStrobeRdy;
                sent <= sent + 4'h1;
            end
        end
    end
    always @(cardOut.hstrobeRdy) begin
        if (running && dirOut && !cardOut.stop && !cardOut.dmackN) begin
            outPair = {outPair[15:0], cardOut.dataOut};
            outCount = outCount + 4'h1;
        end
    end
    always @(posedge cardOut.dmackN) crcSeen = cardOut.dataOut;
endmodule

// [testbench.sv]
`timescale 1ns/10ps
`include "card_host_defs.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module testbench;
    import card_host_pkg::*;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic linkClock = 1'b0, request = 1'b0, dirOut = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, outPair;
    logic [3:0] outCount;
    logic [15:0] crcSeen, crc;
    card_in_t cardIn;
    card_out_t cardOut;
    int n_errors = 0, checked = 0;
    always #2.5 clock = ~clock;
    always #24 linkClock = ~linkClock;
    card_host_port DUT (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cardIn(cardIn), .cardOut(cardOut));
    card_model card (.linkClock(linkClock), .request(request), .dirOut(dirOut), .cardOut(cardOut),
        .cardIn(cardIn), .outPair(outPair), .outCount(outCount), .crcSeen(crcSeen));
    function automatic logic [15:0] crcNext(input logic [15:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            $display("unexpected pready: expected 1, seen %b", pready);
            conclude();
        end
        @(posedge clock);
    endtask
    task automatic waitBit(input int idx, input logic val);
        int n;
        n = 0;
        do begin
            apb(1'b0, `OFF_STATUS, 32'h0000_0000);
            n++;
        end while (rd[idx] !== val && n < 400);
        if (rd[idx] !== val) begin
            n_errors++;
            $display("unexpected status bit %0d: expected %b, seen %b", idx, val, rd[idx]);
            conclude();
        end
    endtask
    task automatic testReset();
        `CHK("idle stop", 1'b1, cardOut.stop)
        `CHK("idle ack", 1'b1, cardOut.dmackN)
        `CHK("idle attribute select", 1'b1, cardOut.regN)
        apb(1'b0, `OFF_CTRL, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0000, rd)
        apb(1'b0, `OFF_STATUS, 32'h0000_0000);
        `CHK("status", 32'h0000_0000, rd)
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        // the pin follows the control register one clock after the write lands
        @(posedge clock);
        `CHK("strap low", 1'b0, cardOut.ideEmulationSelectN)
        `CHK("card mode kept", 1'b0, card.ideMode)
        apb(1'b1, `OFF_CTRL, 32'h0000_0000);
        @(posedge clock);
        `CHK("strap high", 1'b1, cardOut.ideEmulationSelectN)
        $display("reset and registers done");
    endtask
    task automatic memAccess(input logic [31:0] ctrl, input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b1, `OFF_CTRL, ctrl);
        apb(1'b1, `OFF_ADDR, addr);
        apb(1'b1, `OFF_CMD, 32'h0000_0004);
        waitBit(4, 1'b0);
        apb(1'b0, `OFF_MEMDATA, 32'h0000_0000);
        `CHK("memory word", exp, rd)
    endtask
    task automatic testMemory();
        apb(1'b1, `OFF_MEMDATA, 32'h0000_5a3c);
        memAccess(32'h0000_0040, 32'h0000_0005, 32'h0000_5a3c);
        `CHK("common store", 16'h5a3c, card.common[5])
        apb(1'b1, `OFF_MEMDATA, 32'h0000_0000);
        memAccess(32'h0000_0000, 32'h0000_0005, 32'h0000_5a3c);
        memAccess(32'h0000_0020, 32'h0000_0000, 32'h0000_0001);
        memAccess(32'h0000_0020, 32'h0000_0002, 32'h0000_0004);
        apb(1'b1, `OFF_MEMDATA, 32'h0000_0002);
        memAccess(32'h0000_0060, 32'h0000_0200, 32'h0000_0002);
        `CHK("primary decode", 32'h01f0_03f6, card.ioBase)
        apb(1'b1, `OFF_MEMDATA, 32'h0000_0003);
        memAccess(32'h0000_0060, 32'h0000_0200, 32'h0000_0003);
        `CHK("secondary decode", 32'h0170_0376, card.ioBase)
        apb(1'b1, `OFF_MEMDATA, 32'h0000_0000);
        memAccess(32'h0000_0060, 32'h0000_0200, 32'h0000_0000);
        `CHK("memory interface", 32'h0000_0000, card.ioBase)
        $display("memory access done");
    endtask
    task automatic testDataIn();
        crc = `CRC_SEED;
        apb(1'b1, `OFF_CTRL, 32'h0000_0008);
        apb(1'b1, `OFF_CMD, 32'h0000_0001);
        request <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            waitBit(7, 1'b1);
            apb(1'b0, `OFF_RXDATA, 32'h0000_0000);
            `CHK("data in word", 32'h0000_1000 + k, rd)
            crc = crcNext(crc, 16'h1000 + 16'(k));
        end
        apb(1'b1, `OFF_CMD, 32'h0000_0002);
        waitBit(4, 1'b0);
        request <= 1'b0;
        apb(1'b0, `OFF_CRC, 32'h0000_0000);
        `CHK("data in crc", {16'h0000, crc}, rd)
        `CHK("data in crc on pins", crc, crcSeen)
        $display("data in burst done");
    endtask
    task automatic testDataOut();
        crc = crcNext(crcNext(`CRC_SEED, 16'hc3a5), 16'h0f1e);
        dirOut <= 1'b1;
        apb(1'b1, `OFF_CTRL, 32'h0000_0018);
        apb(1'b1, `OFF_TXDATA, 32'h0000_c3a5);
        apb(1'b1, `OFF_CMD, 32'h0000_0001);
        request <= 1'b1;
        waitBit(8, 1'b0);
        apb(1'b1, `OFF_TXDATA, 32'h0000_0f1e);
        waitBit(8, 1'b0);
        apb(1'b1, `OFF_CMD, 32'h0000_0002);
        waitBit(4, 1'b0);
        request <= 1'b0;
        `CHK("data out edges", 4'h2, outCount)
        `CHK("data out words", 32'hc3a5_0f1e, outPair)
        `CHK("data out crc on pins", crc, crcSeen)
        $display("data out burst done");
    endtask
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        testReset();
        testMemory();
        testDataIn();
        testDataOut();
        conclude();
    end
endmodule
